// *** logic/decimator_status_and_output_format.sv ***
// decimator output data register, status word and serial read-out
// Operation
// - results are 24-bit two's complement, bounded span
// - 24-bit status word: errors high, config low
// - summary error is OR of three error flags
// - error flags clear after status read, reset
// - error pin is inverse of summary flag
// - overwrite set when result lands during data read
// - modulator bit follows its pin each edge while settled; its rise clears settled
// - modulator bit holds in power-down and reset
// - overflow sets accumulator flag, clips full scale
// - settled cleared on reset, power-up, wake
// - settled cleared on sync, pin change, modflag
// - unsettled filter keeps four status flags from setting
// - four consecutive samples beyond the same end of the range set range flag
// - bit 18 data ready; low bits mirror config
// - both modes load all-zero config during reset
`timescale 1ns/100ps
`include "decim_status_defines.svh"
module decimator_status_and_output_format
   import decim_status_pkg::*;
(
   input  wire logic               clk,                   // filter clock
   input  wire logic               rstn,                  // async reset, active low
   input  wire logic               result_valid,          // raw filter result strobe
   input  wire logic [`RAW_W-1:0]  result_raw,            // raw signed accumulator result
   input  wire logic [15:0]        sw_config,             // software configuration word
   input  wire logic               hw_config_mode,        // pin: 1 = config from pins
   input  wire logic [4:0]         gain_pins,             // pin: gain and input select
   input  wire logic [2:0]         bandwidth_pins,        // pin: bandwidth select
   input  wire logic               test_input_select_pin, // pin: test input select
   input  wire logic               power_down_pin,        // pin: power-down request
   input  wire logic               modulator_flag_in,     // pin: modulator flag
   input  wire logic               sync_in,               // pin: convolution restart
   input  wire logic               sclk,                  // pin: serial clock
   input  wire logic               cs_n,                  // pin: serial select, active low
   input  wire logic               register_select,       // pin: 1 = data, 0 = status
   output logic                    dout,                  // serial data out
   output logic                    data_ready_out,        // new result waiting
   output logic                    error_n,               // summary error, active low
   output logic      [`WORD_W-1:0] data_word              // output data register
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation

   logic [`PIN_SYNC_W-1:0] pin_raw;
   logic [`PIN_SYNC_W-1:0] pin_s;
   logic [4:0]             gain_s;
   logic [2:0]             bw_s;
   logic                   test_s;
   logic                   pd_s;
   logic                   modflag_s;
   logic                   sync_s;
   logic                   sclk_s;
   logic                   csn_s;
   logic                   register_select_s;
   logic                   hw_s;

   assign pin_raw = {hw_config_mode, register_select, cs_n, sclk, sync_in, modulator_flag_in,
                     power_down_pin, test_input_select_pin, bandwidth_pins, gain_pins};

   pin_sync #(
      .WIDTH (`PIN_SYNC_W),
      .INIT  (`PIN_SYNC_INIT)
   ) u_pin_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (pin_raw),
      .q    (pin_s)
   );

   assign gain_s    = pin_s[4:0];
   assign bw_s      = pin_s[7:5];
   assign test_s    = pin_s[8];
   assign pd_s      = pin_s[9];
   assign modflag_s = pin_s[10];
   assign sync_s    = pin_s[11];
   assign sclk_s    = pin_s[12];
   assign csn_s     = pin_s[13];
   assign register_select_s    = pin_s[14];
   assign hw_s      = pin_s[15];

   ////////////////////////////////////////////////////////////////////////////
   // configuration

   logic    in_reset_reg;
   config_s pin_cfg;
   config_s sw_cfg;
   config_s cfg_reg;
   config_s pin_prev_reg;
   logic    pin_change;
   logic    pd_prev_reg;
   logic    pd_exit;
   logic    sync_prev_reg;
   logic    sync_rise;

   assign pin_cfg = '{power_down: pd_s, test_sel: test_s, bw: bw_s, gain: gain_s};
   assign sw_cfg  = '{power_down: sw_config[`CF_POWER], test_sel: sw_config[`CF_TEST],
                      bw: sw_config[`CF_BW_HI:`CF_BW_LO], gain: sw_config[`CF_GAIN_HI:`CF_GAIN_LO]};

   // stays high for the first edge after release so config keeps loading pin_cfg
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_reset_reg <= 1'b1;
      end else begin
         in_reset_reg <= 1'b0;
      end
   end

   // no async reset here: while reset is held this register loads pin_cfg, which
   // pin_sync holds at its INIT value, so it leaves reset with an all-zero config
   always_ff @(posedge clk) begin
      if (hw_s || in_reset_reg) begin
         cfg_reg <= pin_cfg;
      end else begin
         cfg_reg <= sw_cfg;
      end
      pin_prev_reg <= pin_cfg;
   end

   // power-down is excluded: leaving it has its own restart term
   assign pin_change = hw_s && !in_reset_reg &&
                       ({pin_cfg.test_sel, pin_cfg.bw, pin_cfg.gain} !=
                        {pin_prev_reg.test_sel, pin_prev_reg.bw, pin_prev_reg.gain});

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pd_prev_reg   <= 1'b0;
         sync_prev_reg <= 1'b0;
      end else begin
         pd_prev_reg   <= cfg_reg.power_down;
         sync_prev_reg <= sync_s;
      end
   end

   assign pd_exit   = pd_prev_reg && !cfg_reg.power_down;
   assign sync_rise = sync_s && !sync_prev_reg;

   ////////////////////////////////////////////////////////////////////////////
   // result coding and data register

   logic               word_valid;
   logic [`WORD_W-1:0] word_out;
   logic               clip_evt;
   logic               oor_evt;

   range_checker u_range_checker (
      .clk          (clk),
      .rstn         (rstn),
      .sample_valid (result_valid),
      .sample_raw   (result_raw),
      .word_valid   (word_valid),
      .word_out     (word_out),
      .clip_evt     (clip_evt),
      .oor_evt      (oor_evt)
   );

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_word <= 24'h000000;
      end else if (word_valid) begin
         data_word <= word_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial read-out

   rd_kind_e           rd_kind_reg;
   logic [4:0]         bit_cnt_reg;
   logic [`WORD_W-1:0] shift_reg;
   logic               pending_reg;
   logic               sclk_prev_reg;
   logic               csn_prev_reg;
   logic               sclk_rise;
   logic               sclk_fall;
   logic               cs_fall;
   logic               cs_rise;
   logic               word_done;
   logic               status_done;
   logic               data_busy;
   logic               data_load;
   logic               word_load;
   logic [`WORD_W-1:0] status_word;
   logic               data_ready_reg;

   function automatic logic [`WORD_W-1:0] pick_word(input logic sel, input logic [`WORD_W-1:0] dat,
                                                    input logic [`WORD_W-1:0] st);
      pick_word = sel ? dat : st;
   endfunction : pick_word

   function automatic rd_kind_e pick_kind(input logic sel);
      pick_kind = sel ? RD_DATA : RD_STATUS;
   endfunction : pick_kind

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclk_prev_reg <= 1'b0;
         csn_prev_reg  <= 1'b1;
      end else begin
         sclk_prev_reg <= sclk_s;
         csn_prev_reg  <= csn_s;
      end
   end

   assign sclk_rise   = sclk_s && !sclk_prev_reg;
   assign sclk_fall   = !sclk_s && sclk_prev_reg;
   assign cs_fall     = !csn_s && csn_prev_reg;
   assign cs_rise     = csn_s && !csn_prev_reg;
   assign word_done   = (rd_kind_reg != RD_IDLE) && sclk_rise && (bit_cnt_reg == `BIT_LAST);
   assign status_done = word_done && (rd_kind_reg == RD_STATUS);
   assign data_busy   = (rd_kind_reg == RD_DATA);
   assign word_load   = !cs_rise && (cs_fall || word_done);
   assign data_load   = word_load && register_select_s;

   // the next word is latched at the last rising edge of the previous one, so
   // a host that ties data-ready to register-select gets status second
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_kind_reg <= RD_IDLE;
         bit_cnt_reg <= 5'h00;
         shift_reg   <= 24'h000000;
         pending_reg <= 1'b0;
      end else if (cs_rise) begin
         rd_kind_reg <= RD_IDLE;
         pending_reg <= 1'b0;
      end else if (word_load) begin
         shift_reg   <= pick_word(register_select_s, data_word, status_word);
         rd_kind_reg <= pick_kind(register_select_s);
         bit_cnt_reg <= 5'h00;
         pending_reg <= 1'b0;
      end else if (rd_kind_reg != RD_IDLE) begin
         if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            pending_reg <= 1'b1;
         end else if (sclk_fall && pending_reg) begin
            shift_reg   <= {shift_reg[`WORD_W-2:0], 1'b0};
            pending_reg <= 1'b0;
         end
      end
   end

   assign dout = shift_reg[`WORD_W-1];

   // a result landing in the cycle a data read starts keeps ready high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_ready_reg <= 1'b0;
      end else if (word_valid) begin
         data_ready_reg <= 1'b1;
      end else if (data_load) begin
         data_ready_reg <= 1'b0;
      end
   end

   assign data_ready_out = data_ready_reg;

   ////////////////////////////////////////////////////////////////////////////
   // settling

   logic       settled_reg;
   logic [3:0] settle_cnt_reg;
   logic       modflag_reg;
   logic       modflag_next;
   logic       restart;

   assign restart = in_reset_reg || sync_rise || pin_change || pd_exit ||
                    (modflag_next && !modflag_reg);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         settled_reg    <= 1'b0;
         settle_cnt_reg <= 4'h0;
      end else if (restart) begin
         settled_reg    <= 1'b0;
         settle_cnt_reg <= 4'h0;
      end else if (word_valid && !settled_reg) begin
         settle_cnt_reg <= settle_cnt_reg + 4'h1;
         settled_reg    <= (settle_cnt_reg == `SETTLE_RESULTS - 4'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error flags

   logic overwrite_reg;
   logic overwrite_next;
   logic accum_err_reg;
   logic accum_err_next;
   logic range_reg;
   logic range_next;
   logic error_n_reg;

   // clear first, then sets, so an event in the clearing cycle survives
   always_comb begin
      overwrite_next = status_done ? 1'b0 : overwrite_reg;
      modflag_next   = status_done ? 1'b0 : modflag_reg;
      accum_err_next = status_done ? 1'b0 : accum_err_reg;
      range_next     = status_done ? 1'b0 : range_reg;
      if (settled_reg) begin
         if (word_valid && data_busy) begin
            overwrite_next = 1'b1;
         end
         if (!cfg_reg.power_down && !in_reset_reg) begin
            modflag_next = modflag_s;
         end
         if (clip_evt) begin
            accum_err_next = 1'b1;
         end
         if (oor_evt) begin
            range_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         overwrite_reg <= 1'b0;
         modflag_reg   <= 1'b0;
         accum_err_reg <= 1'b0;
         range_reg     <= 1'b0;
         error_n_reg   <= 1'b1;
      end else begin
         overwrite_reg <= overwrite_next;
         modflag_reg   <= modflag_next;
         accum_err_reg <= accum_err_next;
         range_reg     <= range_next;
         error_n_reg   <= !(overwrite_next || modflag_next || accum_err_next);
      end
   end

   assign error_n = error_n_reg;

   ////////////////////////////////////////////////////////////////////////////
   // status word assembly

   always_comb begin
      status_word                              = 24'h000000;
      status_word[`ST_ERROR]                   = overwrite_reg || modflag_reg || accum_err_reg;
      status_word[`ST_OVERWRITE]               = overwrite_reg;
      status_word[`ST_MODFLAG]                 = modflag_reg;
      status_word[`ST_ACCUM]                   = accum_err_reg;
      status_word[`ST_READY]                   = data_ready_reg;
      status_word[`ST_SETTLED]                 = settled_reg;
      status_word[`ST_RANGE]                   = range_reg;
      status_word[`CF_POWER]                   = cfg_reg.power_down;
      status_word[`CF_TEST]                    = cfg_reg.test_sel;
      status_word[`CF_BW_HI:`CF_BW_LO]         = cfg_reg.bw;
      status_word[`CF_GAIN_HI:`CF_GAIN_LO]     = cfg_reg.gain;
   end

endmodule : decimator_status_and_output_format

// *** logic/decim_status_defines.svh ***
// constants for the decimator output coding and status word
`ifndef DECIM_STATUS_DEFINES_SVH
`define DECIM_STATUS_DEFINES_SVH

`define WORD_W          24
`define RAW_W           35
`define BIT_LAST        5'h17
`define POS_FS          24'h7FFFFF
`define NEG_FS          24'h800000
`define CLIP_HI         35'h0007FFFFF
`define CLIP_LO         35'h7FF800000
`define RANGE_HI        35'h0005FFFFF
`define RANGE_LO        35'h7FFA00000
`define OOR_RUN         3'h4
`define SETTLE_RESULTS  4'h3
`define PIN_SYNC_W      16
`define PIN_SYNC_INIT   16'h2000

`define ST_ERROR        23
`define ST_OVERWRITE    22
`define ST_MODFLAG      21
`define ST_ACCUM        19
`define ST_READY        18
`define ST_SETTLED      17
`define ST_RANGE        16
`define CF_POWER        11
`define CF_TEST         10
`define CF_BW_HI        8
`define CF_BW_LO        6
`define CF_GAIN_HI      4
`define CF_GAIN_LO      0

`endif

// *** logic/decim_status_pkg.sv ***
// types shared by the decimator status logic
package decim_status_pkg;

   typedef enum logic [1:0] {
      RD_IDLE   = 2'b00,
      RD_DATA   = 2'b01,
      RD_STATUS = 2'b10
   } rd_kind_e;

   typedef struct packed {
      logic       power_down;
      logic       test_sel;
      logic [2:0] bw;
      logic [4:0] gain;
   } config_s;

endpackage : decim_status_pkg

// *** logic/pin_sync.sv ***
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pin_sync #(
   parameter int             WIDTH = 16,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             clk,   // filter clock
   input  wire logic             rstn,  // async reset, active low
   input  wire logic [WIDTH-1:0] d,     // asynchronous pins
   output logic      [WIDTH-1:0] q      // synchronised levels
);

   logic [WIDTH-1:0] meta_reg;

   // meta_reg is read by q only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= INIT;
         q        <= INIT;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : pin_sync

// *** logic/range_checker.sv ***
// clipping of filter results and run detection of out-of-range samples
`timescale 1ns/100ps
`include "decim_status_defines.svh"
module range_checker (
   input  wire logic               clk,          // filter clock
   input  wire logic               rstn,         // async reset, active low
   input  wire logic               sample_valid, // raw accumulator result strobe
   input  wire logic [`RAW_W-1:0]  sample_raw,   // raw signed accumulator value
   output logic                    word_valid,   // clipped word strobe
   output logic      [`WORD_W-1:0] word_out,     // 24-bit two's complement result
   output logic                    clip_evt,     // overflow or underflow seen
   output logic                    oor_evt       // fourth or later out-of-range sample
);

   logic       hi;
   logic       lo;
   logic [2:0] run_reg;
   logic [2:0] run_next;
   logic       dir_reg;

   assign hi = $signed(sample_raw) > $signed(`RANGE_HI);
   assign lo = $signed(sample_raw) < $signed(`RANGE_LO);

   // a run only counts samples beyond the same end of the range
   always_comb begin
      run_next = 3'h0;
      if (hi || lo) begin
         if (run_reg != 3'h0 && dir_reg == hi) begin
            run_next = (run_reg == `OOR_RUN) ? run_reg : run_reg + 3'h1;
         end else begin
            run_next = 3'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         word_valid <= 1'b0;
         word_out   <= 24'h000000;
         clip_evt   <= 1'b0;
         oor_evt    <= 1'b0;
         run_reg    <= 3'h0;
         dir_reg    <= 1'b0;
      end else begin
         word_valid <= sample_valid;
         clip_evt   <= 1'b0;
         oor_evt    <= 1'b0;
         if (sample_valid) begin
            if ($signed(sample_raw) > $signed(`CLIP_HI)) begin
               word_out <= `POS_FS;
               clip_evt <= 1'b1;
            end else if ($signed(sample_raw) < $signed(`CLIP_LO)) begin
               word_out <= `NEG_FS;
               clip_evt <= 1'b1;
            end else begin
               word_out <= sample_raw[`WORD_W-1:0];
            end
            run_reg <= run_next;
            dir_reg <= hi;
            oor_evt <= (run_next == `OOR_RUN);
         end
      end
   end

endmodule : range_checker

// *** tb/decim_status_assertions.sv ***
// port-level assertions for the decimator status and output logic
`timescale 1ns/100ps
`include "decim_status_defines.svh"
module decim_status_assertions (
   input wire logic               clk,               // filter clock
   input wire logic               rstn,              // async reset, active low
   input wire logic               result_valid,      // raw result strobe
   input wire logic [`RAW_W-1:0]  result_raw,        // raw result
   input wire logic               cs_n,              // serial select
   input wire logic               modulator_flag_in, // modulator flag pin
   input wire logic               data_ready_out,    // data ready
   input wire logic               error_n,           // summary error, active low
   input wire logic [`WORD_W-1:0] data_word          // output data register
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // age of the last high modulator flag pin, saturating
   logic [2:0] mf_age;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mf_age <= 3'h7;
      end else if (modulator_flag_in) begin
         mf_age <= 3'h0;
      end else if (mf_age != 3'h7) begin
         mf_age <= mf_age + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_ready_set;
      result_valid |-> ##2 data_ready_out;
   endproperty
   a_ready_set: assert property (p_ready_set)
      else $error("data ready not raised after result");
   property p_ready_rise;
      $rose(data_ready_out) |-> $past(result_valid, 2);
   endproperty
   a_ready_rise: assert property (p_ready_rise)
      else $error("data ready rose without result");
   property p_ready_hold;
      cs_n [*8] ##0 data_ready_out |=> data_ready_out;
   endproperty
   a_ready_hold: assert property (p_ready_hold)
      else $error("data ready dropped without read");
   property p_clip_hi;
      result_valid && ($signed(result_raw) > $signed(`CLIP_HI)) |-> ##2 data_word == `POS_FS;
   endproperty
   a_clip_hi: assert property (p_clip_hi)
      else $error("overflow not clipped to positive full scale");
   property p_clip_lo;
      result_valid && ($signed(result_raw) < $signed(`CLIP_LO)) |-> ##2 data_word == `NEG_FS;
   endproperty
   a_clip_lo: assert property (p_clip_lo)
      else $error("underflow not clipped to negative full scale");
   property p_pass;
      logic [`WORD_W-1:0] v;
      (result_valid && ($signed(result_raw) <= $signed(`CLIP_HI)) && ($signed(result_raw) >= $signed(`CLIP_LO)),
       v = result_raw[`WORD_W-1:0]) |-> ##2 data_word == v;
   endproperty
   a_pass: assert property (p_pass)
      else $error("in-range result not passed unchanged");
   property p_word_src;
      $changed(data_word) |-> $past(result_valid, 2);
   endproperty
   a_word_src: assert property (p_word_src)
      else $error("data word changed without result");
   property p_err_cause;
      $fell(error_n) |-> $past(result_valid, 2) || (mf_age < 3'h6);
   endproperty
   a_err_cause: assert property (p_err_cause)
      else $error("error pin fell without result or modulator flag");
endmodule : decim_status_assertions

// *** tb/host_reader.sv ***
// host model reading words over the serial port
`timescale 1ns/100ps
module host_reader (
   input  wire logic clk,             // filter clock, paces the serial clock
   input  wire logic dout,            // serial data from device
   output logic      sclk,            // serial clock, low outside frames
   output logic      cs_n,            // serial select, active low
   output logic      register_select  // 1 = data, 0 = status
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      register_select = 1'b0;
   end

   // one word per frame; the 48-clock chained read is not used
   task read_word(input logic sel, input int nbits, output logic [23:0] w);
      w = 24'h000000;
      register_select = sel;
      cs_n = 1'b0;
      repeat (8) @(negedge clk);
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'b1;
         w = {w[22:0], dout};
         repeat (4) @(negedge clk);
         sclk = 1'b0;
         repeat (4) @(negedge clk);
      end
      cs_n = 1'b1;
      repeat (8) @(negedge clk);
   endtask : read_word
endmodule : host_reader

// *** tb/test_decimator_status_and_output_format.sv ***
// self-checking bench for the decimator status and output logic
`timescale 1ns/100ps
module test_decimator_status_and_output_format;
   logic        clk, rstn, result_valid, hw_config_mode, test_input_select_pin;
   logic        power_down_pin, modulator_flag_in, sync_in;
   logic [34:0] result_raw;
   logic [15:0] sw_config;
   logic [4:0]  gain_pins;
   logic [2:0]  bandwidth_pins;
   logic [23:0] w;
   wire         sclk, cs_n, register_select, dout, data_ready_out, error_n;
   wire  [23:0] data_word;
   int          err_total, checks;

   decimator_status_and_output_format decimator_status_and_output_format_inst (
      .clk(clk), .rstn(rstn), .result_valid(result_valid), .result_raw(result_raw), .sw_config(sw_config),
      .hw_config_mode(hw_config_mode), .gain_pins(gain_pins), .bandwidth_pins(bandwidth_pins),
      .test_input_select_pin(test_input_select_pin), .power_down_pin(power_down_pin),
      .modulator_flag_in(modulator_flag_in), .sync_in(sync_in), .sclk(sclk), .cs_n(cs_n),
      .register_select(register_select), .dout(dout), .data_ready_out(data_ready_out),
      .error_n(error_n), .data_word(data_word));
   host_reader host_reader_inst (
      .clk(clk), .dout(dout), .sclk(sclk), .cs_n(cs_n), .register_select(register_select));

   ////////////////////////////////////////////////////////////////////////////
   task wrap_up;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   task wclk(input int n);
      repeat (n) @(negedge clk);
   endtask : wclk
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // ready, error pin and data word packed together
   task outs(input logic [31:0] exp);
      chk({6'h00, data_ready_out, error_n, data_word}, exp);
   endtask : outs
   task st(input logic [23:0] exp);
      host_reader_inst.read_word(1'b0, 24, w);
      chk({8'h00, w}, {8'h00, exp});
   endtask : st
   task res(input logic [34:0] v);
      result_valid = 1'b1;
      result_raw = v;
      wclk(1);
      result_valid = 1'b0;
      wclk(2);
   endtask : res
   task settle;
      repeat (3) res(35'h000000000);
   endtask : settle

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      wclk(50000);
      err_total++;
      wrap_up();
   end
   initial begin
      rstn = 1'b0;
      result_valid = 1'b0;
      result_raw = 35'h000000000;
      sw_config = 16'h0000;
      hw_config_mode = 1'b1;
      gain_pins = 5'h15;
      bandwidth_pins = 3'h5;
      test_input_select_pin = 1'b1;
      power_down_pin = 1'b0;
      modulator_flag_in = 1'b0;
      sync_in = 1'b0;
      wclk(5);
      rstn = 1'b1;
      wclk(6);
      outs(32'h01000000);
      st(24'h000555);
      $display("test reset done");
      res(35'h000558105);
      outs(32'h03558105);
      res(35'h7FFB3FF17);
      outs(32'h03B3FF17);
      res(35'h000000000);
      st(24'h060555);
      $display("test format done");
      repeat (3) res(35'h000600000);
      st(24'h060555);
      res(35'h000600000);
      outs(32'h03600000);
      st(24'h070555);
      st(24'h060555);
      res(35'h000000000);
      $display("test range done");
      res(35'h000900000);
      outs(32'h027FFFFF);
      host_reader_inst.read_word(1'b0, 10, w);
      outs(32'h027FFFFF);
      st(24'h8E0555);
      outs(32'h037FFFFF);
      res(35'h7F0000000);
      outs(32'h02800000);
      st(24'h8E0555);
      $display("test clip done");
      host_reader_inst.read_word(1'b1, 24, w);
      chk({8'h00, w}, 32'h00800000);
      outs(32'h01800000);
      fork
         host_reader_inst.read_word(1'b1, 24, w);
         begin
            wclk(40);
            res(35'h000123456);
         end
      join
      chk({8'h00, w}, 32'h00800000);
      outs(32'h00123456);
      st(24'hC20555);
      outs(32'h01123456);
      $display("test overwrite done");
      modulator_flag_in = 1'b1;
      wclk(8);
      outs(32'h00123456);
      modulator_flag_in = 1'b0;
      wclk(8);
      outs(32'h00123456);
      st(24'hA00555);
      settle();
      st(24'h060555);
      $display("test modulator flag done");
      power_down_pin = 1'b1;
      wclk(6);
      modulator_flag_in = 1'b1;
      wclk(8);
      outs(32'h03000000);
      modulator_flag_in = 1'b0;
      wclk(6);
      power_down_pin = 1'b0;
      wclk(6);
      st(24'h040555);
      $display("test power-down done");
      settle();
      st(24'h060555);
      sync_in = 1'b1;
      wclk(6);
      sync_in = 1'b0;
      wclk(2);
      st(24'h040555);
      settle();
      gain_pins = 5'h0A;
      wclk(6);
      st(24'h04054A);
      // software mode: the mirror shows the written word
      hw_config_mode = 1'b0;
      sw_config = 16'h04CA;
      wclk(6);
      st(24'h0404CA);
      $display("test restart and config done");
      wrap_up();
   end
endmodule : test_decimator_status_and_output_format

bind decimator_status_and_output_format decim_status_assertions decim_status_assertions_inst (
   .clk(clk), .rstn(rstn), .result_valid(result_valid), .result_raw(result_raw), .cs_n(cs_n),
   .modulator_flag_in(modulator_flag_in), .data_ready_out(data_ready_out), .error_n(error_n),
   .data_word(data_word));
